/* File: logic/pcs_defines.svh */
// offsets, field positions, reset values and timing counts of the pll block
`ifndef PCS_DEFINES_SVH
`define PCS_DEFINES_SVH

// structure
`define PCS_NPLL 4
`define PCS_NEXT 2

// register byte offsets
`define PCS_CFG_BASE 8'h00
`define PCS_SHIFT_BASE 8'h10
`define PCS_STATUS 8'h20
`define PCS_IRQ_ST 8'h24
`define PCS_IRQ_MASK 8'h28
`define PCS_GPIO 8'h2C

// config word field positions
`define PCS_F_M 0
`define PCS_F_K 8
`define PCS_F_N 16
`define PCS_F_V 21
`define PCS_F_MODE 26
`define PCS_F_PHASE 28
`define PCS_F_EN_SEL 30
`define PCS_F_LOCK_USE 31

// irq status field positions
`define PCS_F_IRQ_RISE 0
`define PCS_F_IRQ_FALL 4
`define PCS_F_IRQ_CFG 8

// reset values
`define PCS_CFG_RST 32'hC021_0101
`define PCS_SHIFT_RST 8'h00
`define PCS_MASK_RST 12'h000
`define PCS_GPIO_RST 8'h00

// scaling limits
`define PCS_MK_MIN 8'h01
`define PCS_MK_MAX 8'hA0
`define PCS_NV_MIN 5'h01
`define PCS_NV_MAX 5'h10

// timing
`define PCS_CLK_NS 20
`define PCS_REF_MIN_NS 100
`define PCS_REF_MAX_NS 20000
`define PCS_FB_WIN_NS 60
`define PCS_REF_MIN_CYC ((`PCS_REF_MIN_NS + `PCS_CLK_NS - 1) / `PCS_CLK_NS)
`define PCS_REF_MAX_CYC (`PCS_REF_MAX_NS / `PCS_CLK_NS)
`define PCS_FB_WIN_CYC (`PCS_FB_WIN_NS / `PCS_CLK_NS)
`define PCS_REF_TOL_CYC 1
`define PCS_LOCK_EDGES 8

`endif

/* File: logic/pcs_pkg.sv */
// types shared by the pll clock synthesis control block
package pcs_pkg;

  typedef enum logic [1:0] {
    PCS_NORMAL,
    PCS_ZDB,
    PCS_EXTFB
  } pcs_mode_t;

  typedef enum logic [1:0] {
    PCS_OFF,
    PCS_ACQ,
    PCS_LOCK
  } pcs_lock_st_t;

  typedef struct packed {
    logic lock_use;
    logic en_sel;
    logic [1:0] phase;
    pcs_mode_t mode;
    logic [4:0] v;
    logic [4:0] n;
    logic [7:0] k;
    logic [7:0] m;
  } pcs_cfg_t;

  typedef struct packed {
    logic [3:0] cfg_err;
    logic [3:0] lock_fall;
    logic [3:0] lock_rise;
  } pcs_irq_t;

endpackage : pcs_pkg

/* File: logic/pcs_pll_ctrl.sv */
// pll clock synthesis control: lock, scaling, phase, gating, apb regs
`timescale 1ns/1ps
`include "pcs_defines.svh"

module pcs_pll_ctrl import pcs_pkg::*; (
  // system
  input wire logic clk,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // reference, feedback and enable pins
  input wire logic [`PCS_NPLL-1:0] ref_clk_pin,
  input wire logic [`PCS_NEXT-1:0] fb_clk_pin,
  input wire logic pll_global_enable_pin,
  // lock pins, two-way
  input wire logic [`PCS_NPLL-1:0] lock_pin_i,
  output logic [`PCS_NPLL-1:0] lock_pin_o,
  output logic [`PCS_NPLL-1:0] lock_pin_oe,
  // synthesized clocks
  output logic [`PCS_NPLL-1:0] synth_out_a,
  output logic [`PCS_NPLL-1:0] synth_out_b,
  output logic [`PCS_NEXT-1:0] ext_clk_out,
  output logic [`PCS_NEXT-1:0] io_element_clk,
  // interrupt
  output logic irq
);

  localparam int NP = `PCS_NPLL;
  localparam int NE = `PCS_NEXT;
  localparam int SW = 2 * NP + NE + 1;

  // scaling check for config writes
  function automatic logic cfg_legal(input pcs_cfg_t c,
                                     input logic [7:0] fine);
    logic [11:0] nk;
    logic [11:0] nv;
    logic [11:0] m12;
    logic shifted;
    logic ok;
    nk = 12'(c.n) * 12'(c.k);
    nv = 12'(c.n) * 12'(c.v);
    m12 = 12'(c.m);
    shifted = (c.phase != 2'h0) || (fine != 8'h00);
    ok = (c.m >= `PCS_MK_MIN) && (c.m <= `PCS_MK_MAX) &&
         (c.k >= `PCS_MK_MIN) && (c.k <= `PCS_MK_MAX) &&
         (c.n >= `PCS_NV_MIN) && (c.n <= `PCS_NV_MAX) &&
         (c.v >= `PCS_NV_MIN) && (c.v <= `PCS_NV_MAX) &&
         (c.mode inside {PCS_NORMAL, PCS_ZDB, PCS_EXTFB});
    // aligned modes forbid multiply and shift
    if (ok && (c.mode != PCS_NORMAL)) begin
      ok = !shifted && (m12 <= nk) && (m12 <= nv);
    end
    if (ok && shifted) begin
      ok = ((nk % m12 == 12'h000) || (m12 % nk == 12'h000)) &&
           ((nv % m12 == 12'h000) || (m12 % nv == 12'h000));
    end
    return ok;
  endfunction : cfg_legal

  // pin synchronisers
  logic [SW-1:0] sync1_r;
  logic [SW-1:0] sync2_r;
  logic [SW-1:0] sync3_r;
  wire [SW-1:0] pins_w = {pll_global_enable_pin, lock_pin_i, fb_clk_pin,
                          ref_clk_pin};

  always_ff @(posedge clk) begin
    if (rst) begin
      sync1_r <= '0;
      sync2_r <= '0;
      sync3_r <= '0;
    end else begin
      sync1_r <= pins_w;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  wire [NP-1:0] ref_rise = sync2_r[NP-1:0] & ~sync3_r[NP-1:0];
  wire [NE-1:0] fb_rise = sync2_r[NP+NE-1:NP] & ~sync3_r[NP+NE-1:NP];
  wire [NP-1:0] lkin_s = sync2_r[2*NP+NE-1:NP+NE];
  wire [NP-1:0] lkin_d = sync3_r[2*NP+NE-1:NP+NE];
  wire en_s = sync2_r[SW-1];

  // apb decode
  wire apb_setup = psel & ~penable;
  wire apb_acc = psel & penable;
  wire apb_wr = apb_acc & pwrite;
  wire apb_rd = apb_acc & ~pwrite;
  wire [1:0] idx = paddr[3:2];
  wire aligned = paddr[1:0] == 2'h0;
  wire hit_cfg = aligned && (paddr[7:4] == `PCS_CFG_BASE >> 4);
  wire hit_shift = aligned && (paddr[7:4] == `PCS_SHIFT_BASE >> 4);
  wire hit_st = paddr == `PCS_STATUS;
  wire hit_irq = paddr == `PCS_IRQ_ST;
  wire hit_mask = paddr == `PCS_IRQ_MASK;
  wire hit_gpio = paddr == `PCS_GPIO;
  wire hit_any = hit_cfg | hit_shift | hit_st | hit_irq | hit_mask |
                 hit_gpio;

  // per-pll state gathered for reads and outputs
  pcs_cfg_t cfg_all [NP];
  logic [7:0] shift_all [NP];
  logic [NP-1:0] gated_w;
  logic [NP-1:0] acq_w;
  logic [NP-1:0] off_w;
  logic [NP-1:0] cfg_bad_w;
  logic [NP-1:0] out_a_w;
  logic [NP-1:0] out_b_w;

  // common registers
  logic [31:0] prdata_r;
  pcs_irq_t irq_st_r;
  logic [11:0] mask_r;
  logic [7:0] gpio_r;

  wire [31:0] status_w = {12'h000, lkin_s, 3'h0, en_s, off_w, gated_w,
                          acq_w};
  wire [31:0] gpio_w = {20'h0_0000, lkin_s, gpio_r};
  wire [31:0] rd_val = hit_cfg ? 32'(cfg_all[idx]) :
                       hit_shift ? {24'h00_0000, shift_all[idx]} :
                       hit_st ? status_w :
                       hit_irq ? {20'h0_0000, irq_st_r} :
                       hit_mask ? {20'h0_0000, mask_r} :
                       hit_gpio ? gpio_w : 32'h0000_0000;

  // lock seen internally only through the pin loopback
  wire pcs_irq_t ev_w = '{cfg_err: cfg_bad_w,
                          lock_fall: ~lkin_s & lkin_d,
                          lock_rise: lkin_s & ~lkin_d};
  wire clr_irq = apb_rd & hit_irq;

  assign pready = 1'b1;
  assign pslverr = apb_acc & ~hit_any;
  assign prdata = prdata_r;
  assign irq = |(12'(irq_st_r) & mask_r);

  always_ff @(posedge clk) begin
    if (rst) begin
      prdata_r <= 32'h0000_0000;
    end else if (apb_setup) begin
      prdata_r <= pwrite ? 32'h0000_0000 : rd_val;
    end
  end

  // sticky events, clear only what the read returned; set wins
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_st_r <= '0;
    end else begin
      irq_st_r <= (irq_st_r & ~(clr_irq ? prdata_r[11:0] : 12'h000)) |
                  ev_w;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      mask_r <= `PCS_MASK_RST;
      gpio_r <= `PCS_GPIO_RST;
    end else begin
      if (apb_wr && hit_mask) begin
        mask_r <= pwdata[11:0];
      end
      if (apb_wr && hit_gpio) begin
        gpio_r <= pwdata[7:0];
      end
    end
  end

  genvar i;
  genvar j;
  generate
    for (i = 0; i < NP; i++) begin : g_pll
      pcs_cfg_t cfg_r;
      logic [7:0] shift_r;
      pcs_lock_st_t st_r;
      pcs_lock_st_t st_nxt;
      logic [15:0] pcnt_r;
      logic [15:0] per_r;
      logic [3:0] good_r;
      logic [3:0] fb_age_r;
      logic lock_o_r;
      logic lock_oe_r;

      wire sel = idx == 2'(i);
      wire cfg_wr_req = apb_wr & hit_cfg & sel;
      wire sh_wr_req = apb_wr & hit_shift & sel;
      wire cfg_ok = cfg_legal(pcs_cfg_t'(pwdata), shift_r);
      wire sh_ok = cfg_legal(cfg_r, pwdata[7:0]);
      wire restart = (cfg_wr_req & cfg_ok) | (sh_wr_req & sh_ok);
      // only selected plls follow the enable pin
      wire gated = cfg_r.en_sel & ~en_s;
      wire [15:0] diff = (pcnt_r >= per_r) ? pcnt_r - per_r :
                         per_r - pcnt_r;
      wire spec_ok = (pcnt_r >= 16'(`PCS_REF_MIN_CYC)) &&
                     (pcnt_r <= 16'(`PCS_REF_MAX_CYC)) &&
                     (diff <= 16'(`PCS_REF_TOL_CYC));
      wire timeout = pcnt_r > 16'(`PCS_REF_MAX_CYC);
      // feedback edge must sit beside the reference edge
      wire fb_ok = (cfg_r.mode != PCS_EXTFB) || fb_rise[i/2] ||
                   (fb_age_r <= 4'(`PCS_FB_WIN_CYC));
      wire edge_good = ref_rise[i] & spec_ok & fb_ok;
      wire edge_bad = ref_rise[i] & ~(spec_ok & fb_ok);

      assign cfg_all[i] = cfg_r;
      assign shift_all[i] = shift_r;
      assign gated_w[i] = gated;
      assign acq_w[i] = st_r == PCS_ACQ;
      assign off_w[i] = st_r == PCS_OFF;
      assign cfg_bad_w[i] = (cfg_wr_req & ~cfg_ok) | (sh_wr_req & ~sh_ok);
      assign lock_pin_o[i] = lock_o_r;
      assign lock_pin_oe[i] = lock_oe_r;

      always_ff @(posedge clk) begin
        if (rst) begin
          cfg_r <= pcs_cfg_t'(`PCS_CFG_RST);
          shift_r <= `PCS_SHIFT_RST;
        end else begin
          if (cfg_wr_req && cfg_ok) begin
            cfg_r <= pcs_cfg_t'(pwdata);
          end
          if (sh_wr_req && sh_ok) begin
            shift_r <= pwdata[7:0];
          end
        end
      end

      always_comb begin
        st_nxt = st_r;
        unique case (st_r)
          PCS_OFF: begin
            st_nxt = PCS_ACQ;
          end
          PCS_ACQ: begin
            if (edge_good && good_r == 4'(`PCS_LOCK_EDGES - 1)) begin
              st_nxt = PCS_LOCK;
            end
          end
          PCS_LOCK: begin
            if (timeout || edge_bad || restart) begin
              st_nxt = PCS_ACQ;
            end
          end
        endcase
        if (gated) begin
          st_nxt = PCS_OFF;
        end
      end

      always_ff @(posedge clk) begin
        if (rst) begin
          st_r <= PCS_OFF;
        end else begin
          st_r <= st_nxt;
        end
      end

      always_ff @(posedge clk) begin
        if (rst || st_nxt != PCS_ACQ || timeout || edge_bad || restart) begin
          good_r <= 4'h0;
        end else if (edge_good) begin
          good_r <= good_r + 4'h1;
        end
      end

      always_ff @(posedge clk) begin
        if (rst || gated) begin
          pcnt_r <= 16'h0000;
          per_r <= 16'h0000;
        end else if (ref_rise[i]) begin
          pcnt_r <= 16'h0001;
          per_r <= pcnt_r;
        end else if (pcnt_r != 16'hFFFF) begin
          pcnt_r <= pcnt_r + 16'h0001;
        end
      end

      always_ff @(posedge clk) begin
        if (rst || fb_rise[i/2]) begin
          fb_age_r <= 4'h0;
        end else if (fb_age_r != 4'hF) begin
          fb_age_r <= fb_age_r + 4'h1;
        end
      end

      // lock pin, or general i/o when unused
      always_ff @(posedge clk) begin
        if (rst) begin
          lock_o_r <= 1'b0;
          lock_oe_r <= 1'b0;
        end else if (cfg_r.lock_use) begin
          lock_o_r <= st_r == PCS_LOCK;
          lock_oe_r <= 1'b1;
        end else begin
          lock_o_r <= gpio_r[i];
          lock_oe_r <= gpio_r[4+i];
        end
      end

      for (j = 0; j < 2; j++) begin : g_out
        logic [31:0] acc_r;
        logic [11:0] ec_r;
        logic [7:0] dly_r;
        logic pend_r;
        logic out_r;

        wire [7:0] div = (j == 0) ? cfg_r.k : {3'h0, cfg_r.v};
        wire [11:0] nd = 12'(cfg_r.n) * 12'(div);
        // period span per output cycle is per*n*div/m
        wire [31:0] span = 32'(per_r) * 32'(nd);
        wire [31:0] step = {23'h00_0000, cfg_r.m, 1'b0};
        wire [31:0] sum = acc_r + step;
        wire wrap = sum >= span;
        wire run = (st_r != PCS_OFF) && (per_r != 16'h0000);
        wire ec_end = ec_r >= nd - 12'h001;
        wire align_hit = ref_rise[i] & ec_end;
        // extra delay in whole clock steps
        wire align_now = (align_hit && shift_r == 8'h00) ||
                         (pend_r && dly_r == 8'h01);
        // quarter shifts preset the phase exactly
        wire [31:0] acc_pre = cfg_r.phase[0] ? span >> 1 : 32'h0000_0000;
        wire out_pre = ~(cfg_r.phase[0] ^ cfg_r.phase[1]);

        always_ff @(posedge clk) begin
          if (rst || !run) begin
            ec_r <= 12'hFFF;
          end else if (ref_rise[i]) begin
            ec_r <= ec_end ? 12'h000 : ec_r + 12'h001;
          end
        end

        always_ff @(posedge clk) begin
          if (rst || !run) begin
            pend_r <= 1'b0;
            dly_r <= 8'h00;
          end else if (align_hit && shift_r != 8'h00) begin
            pend_r <= 1'b1;
            dly_r <= shift_r;
          end else if (pend_r) begin
            pend_r <= dly_r != 8'h01;
            dly_r <= dly_r - 8'h01;
          end
        end

        // run while enabled, ground when gated
        always_ff @(posedge clk) begin
          if (rst || !run) begin
            acc_r <= 32'h0000_0000;
            out_r <= 1'b0;
          end else if (align_now) begin
            acc_r <= acc_pre;
            out_r <= out_pre;
          end else if (wrap) begin
            acc_r <= sum - span;
            out_r <= ~out_r;
          end else begin
            acc_r <= sum;
          end
        end

        if (j == 0) begin : g_a
          assign out_a_w[i] = out_r;
        end else begin : g_b
          assign out_b_w[i] = out_r;
        end
      end
    end

    // one external output per pll pair
    for (i = 0; i < NE; i++) begin : g_ext
      logic lag_r;
      wire src = out_a_w[2*i];

      always_ff @(posedge clk) begin
        if (rst) begin
          lag_r <= 1'b0;
        end else begin
          lag_r <= src & ~gated_w[2*i];
        end
      end

      assign ext_clk_out[i] = (cfg_all[2*i].mode == PCS_NORMAL) ? lag_r :
                              src;
      assign io_element_clk[i] = src;
    end
  endgenerate

  assign synth_out_a = out_a_w;
  assign synth_out_b = out_b_w;

endmodule : pcs_pll_ctrl

/* File: tb/pcs_pll_ctrl_chk.sv */
// assertion checker for the pll clock synthesis control block
`timescale 1ns/1ps
`include "pcs_defines.svh"
module pcs_pll_chk (
  // system
  input wire logic clk,
  input wire logic rst,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic pslverr,
  // pins
  input wire logic [`PCS_NPLL-1:0] ref_clk_pin,
  input wire logic pll_global_enable_pin,
  input wire logic [`PCS_NPLL-1:0] lock_pin_o,
  input wire logic [`PCS_NPLL-1:0] synth_out_a,
  input wire logic [`PCS_NPLL-1:0] synth_out_b,
  input wire logic [`PCS_NEXT-1:0] ext_clk_out,
  input wire logic [`PCS_NEXT-1:0] io_element_clk
);
  logic [10:0] gap_r;
  logic [10:0] gap_nxt;
  // cycles the pll0 reference has sat low, saturating
  assign gap_nxt = ref_clk_pin[0] ? 11'h000 :
    (gap_r == 11'h7FF) ? gap_r : gap_r + 11'h001;
  always_ff @(posedge clk) begin
    gap_r <= rst ? 11'h000 : gap_nxt;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_gate_out;
    !pll_global_enable_pin [*6] |->
      !synth_out_a[0] && !synth_out_b[0] && !ext_clk_out[0];
  endproperty
  a_gate_out: assert property (p_gate_out)
    else $error("pll0 clock runs while disabled");
  property p_gate_lock;
    !pll_global_enable_pin [*6] |-> !lock_pin_o[0];
  endproperty
  a_gate_lock: assert property (p_gate_lock)
    else $error("pll0 lock high while disabled");
  property p_relock;
    $rose(pll_global_enable_pin) && !lock_pin_o[0] |=> !lock_pin_o[0] [*8];
  endproperty
  a_relock: assert property (p_relock)
    else $error("pll0 locked without reacquiring");
  property p_lock_spec;
    gap_r > 11'h3FC |-> !lock_pin_o[0];
  endproperty
  a_lock_spec: assert property (p_lock_spec)
    else $error("pll0 lock kept with reference stopped");
  property p_io_align;
    io_element_clk[0] == synth_out_a[0];
  endproperty
  a_io_align: assert property (p_io_align)
    else $error("io clock not aligned to synth output");
  property p_ext_lag;
    pll_global_enable_pin [*6] |-> ext_clk_out[0] == $past(synth_out_a[0]);
  endproperty
  a_ext_lag: assert property (p_ext_lag)
    else $error("external clock lag wrong");
  property p_err_map;
    psel && penable && paddr >= 8'h30 |-> pslverr;
  endproperty
  a_err_map: assert property (p_err_map)
    else $error("unmapped access not refused");
  property p_err_only;
    pslverr |-> psel && penable;
  endproperty
  a_err_only: assert property (p_err_only)
    else $error("error outside access phase");
endmodule : pcs_pll_chk

bind pcs_pll_ctrl pcs_pll_chk u_chk (.clk(clk), .rst(rst), .psel(psel),
  .penable(penable), .paddr(paddr), .pslverr(pslverr),
  .ref_clk_pin(ref_clk_pin), .pll_global_enable_pin(pll_global_enable_pin),
  .lock_pin_o(lock_pin_o), .synth_out_a(synth_out_a),
  .synth_out_b(synth_out_b), .ext_clk_out(ext_clk_out),
  .io_element_clk(io_element_clk));

/* File: tb/pcs_board_model.sv */
// board side: reference clocks, feedback loop, lock pin wiring
`timescale 1ns/1ps
`include "pcs_defines.svh"
module pcs_board_model #(
  parameter int REF_HALF_NS = 100
) (
  // control
  input wire logic run,
  // from device
  input wire logic [`PCS_NEXT-1:0] ext_clk_out,
  input wire logic [`PCS_NPLL-1:0] lock_pin_o,
  input wire logic [`PCS_NPLL-1:0] lock_pin_oe,
  // to device
  output logic [`PCS_NPLL-1:0] ref_clk_pin,
  output logic [`PCS_NEXT-1:0] fb_clk_pin,
  output logic [`PCS_NPLL-1:0] lock_pin_i,
  // board clock user
  output int ext_rises
);
  logic ref_r;
  // reference stops low when not running, phase unrelated to clk
  initial begin
    ref_r = 1'b0;
    #7;
    forever begin
      #(REF_HALF_NS);
      ref_r = run ? ~ref_r : 1'b0;
    end
  end
  assign ref_clk_pin = {`PCS_NPLL{ref_r}};
  assign fb_clk_pin = ext_clk_out;
  // pull-down on undriven lock pins
  assign lock_pin_i = lock_pin_oe & lock_pin_o;
  always @(posedge ext_clk_out[0]) begin
    ext_rises++;
  end
endmodule : pcs_board_model

/* File: tb/test_pll_clock_synth_control.sv */
// bench for the pll clock synthesis control block
`timescale 1ns/1ps
`include "pcs_defines.svh"
module test_pll_clock_synth_control import pcs_pkg::*; ;
  logic clk, rst, psel, penable, pwrite, en, run, e;
  logic pready, pslverr, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [3:0] rf, li, lo, loe, sa, sb;
  logic [1:0] fb, ext, ioc;
  int n_fail, checked, xr;

  pcs_pll_ctrl uut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ref_clk_pin(rf), .fb_clk_pin(fb),
    .pll_global_enable_pin(en), .lock_pin_i(li), .lock_pin_o(lo),
    .lock_pin_oe(loe), .synth_out_a(sa), .synth_out_b(sb),
    .ext_clk_out(ext), .io_element_clk(ioc), .irq(irq));
  pcs_board_model brd (.run(run), .ext_clk_out(ext), .lock_pin_o(lo),
    .lock_pin_oe(loe), .ref_clk_pin(rf), .fb_clk_pin(fb), .lock_pin_i(li),
    .ext_rises(xr));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input string nm, input logic [31:0] x, y);
    checked++;
    if (y !== x) begin
      $display("ERROR %s expected %h seen %h", nm, x, y);
      n_fail++;
    end
  endtask : chk

  task automatic near(input string nm, input int x, y);
    checked++;
    if (y < x - 2 || y > x + 2) begin
      $display("ERROR %s expected %0d seen %0d", nm, x, y);
      n_fail++;
    end
  endtask : near

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : settle

  // one apb transfer; holds the request until pready is seen
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
    if (pready !== 1'b1) begin
      chk("apb ready", 32'h0000_0001, 32'h0000_0000);
      wrap_up();
    end
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0000_0000);
  endtask : rd

  task automatic wt_lock(input logic [3:0] x);
    for (int i = 0; i < 3000 && lo !== x; i++) begin
      @(posedge clk);
      #1;
    end
    chk("lock pins", 32'(x), 32'(lo));
    if (lo !== x) wrap_up();
    #1;
  endtask : wt_lock

  task automatic cnt(input int k, n, output int ca, cb);
    logic pa, pb;
    ca = 0;
    cb = 0;
    pa = sa[k];
    pb = sb[k];
    repeat (n) begin
      settle(1);
      if (sa[k] === 1'b1 && pa === 1'b0) ca++;
      if (sb[k] === 1'b1 && pb === 1'b0) cb++;
      pa = sa[k];
      pb = sb[k];
    end
  endtask : cnt

  task automatic t_reset();
    rd(8'h00);
    chk("cfg0 reset", 32'hC021_0101, q);
    rd(8'h30);
    chk("unmapped err", 32'h0000_0001, 32'(e));
    chk("unmapped data", 32'h0000_0000, q);
    wr(8'h28, 32'h0000_000F);
  endtask : t_reset

  task automatic t_lock();
    wt_lock(4'hF);
    chk("lock oe", 32'h0000_000F, 32'(loe));
    settle(4);
    chk("irq rise", 32'h0000_0001, 32'(irq));
    rd(8'h24);
    chk("irq status", 32'h0000_000F, q);
    settle(1);
    chk("irq cleared", 32'h0000_0000, 32'(irq));
  endtask : t_lock

  task automatic t_freq();
    logic [31:0] cf [3];
    int ca, cb, m, ea, eb, x0;
    cf = '{32'hC021_0101, 32'hC041_0102, 32'hC021_0203};
    foreach (cf[i]) begin
      wr(8'h00, cf[i]);
      settle(4);
      wt_lock(4'hF);
      settle(20);
      m = 20 * cf[i][7:0];
      ea = m / (cf[i][20:16] * cf[i][15:8]);
      eb = m / (cf[i][20:16] * cf[i][25:21]);
      x0 = xr;
      cnt(0, 200, ca, cb);
      near("out a rises", ea, ca);
      near("out b rises", eb, cb);
      near("ext rises", ca, xr - x0);
    end
  endtask : t_freq

  task automatic t_gate();
    int ca, cb;
    wr(8'h04, 32'h8021_0101);
    settle(4);
    wt_lock(4'hF);
    wr(8'h28, 32'h0000_0000);
    @(posedge clk);
    en <= 1'b0;
    settle(20);
    chk("gated outs", 32'h0, 32'({sa[3:2], sa[0], sb[3:2], sb[0], ext}));
    chk("gated lock", 32'h0000_0002, 32'(lo));
    cnt(1, 60, ca, cb);
    near("ungated pll", 6, ca);
    @(posedge clk);
    en <= 1'b1;
    settle(4);
    chk("early lock", 32'h0000_0002, 32'(lo));
    wt_lock(4'hF);
    settle(4);
    chk("masked irq", 32'h0000_0000, 32'(irq));
    wr(8'h28, 32'h0000_00F0);
    settle(1);
    chk("fall irq", 32'h0000_0001, 32'(irq));
    rd(8'h24);
    chk("lock events", 32'h0000_00FF, q);
  endtask : t_gate

  task automatic t_bad();
    logic [31:0] bw [10];
    bw = '{32'hC021_0100, 32'hC021_01A1, 32'hC021_0001, 32'hC020_0101,
      32'hC031_0101, 32'hC221_0101, 32'hCC21_0101, 32'hC421_0102,
      32'hC821_0102, 32'hD421_0101};
    wr(8'h28, 32'h0000_0F00);
    foreach (bw[i]) begin
      wr(8'h08, bw[i]);
      settle(1);
      chk("cfg irq", 32'h0000_0001, 32'(irq));
      rd(8'h08);
      chk("cfg kept", 32'hC021_0101, q);
      rd(8'h24);
      chk("cfg flag", 32'h0000_0400, q);
    end
    wr(8'h08, 32'hC210_A0A0);
    rd(8'h08);
    chk("cfg limits", 32'hC210_A0A0, q);
    wr(8'h14, 32'h0000_0005);
    rd(8'h14);
    chk("shift taken", 32'h0000_0005, q);
    wr(8'h10, 32'h0000_0005);
    rd(8'h10);
    chk("shift refused", 32'h0000_0000, q);
  endtask : t_bad

  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    en = 1'b1;
    run = 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_lock();
    t_freq();
    t_gate();
    t_bad();
    run <= 1'b0;
    wt_lock(4'h0);
    wrap_up();
  end
endmodule : test_pll_clock_synth_control
